// ---- bfl_boot_loader.v ----
// Behaviour
// [RULE1] Sample straps, then enable limited host interface
// [RULE2] Test system supply to find boot source
// [RULE3] Dead battery: read path select, then continue
// [RULE4] Flash holds low and high regions
// [RULE5] Headers at 0x000000 and 0x001000, 4 kB
// [RULE6] Start address is region pointer plus offset
// [RULE7] Leading image bytes are configuration settings
// [RULE8] Try low region first, fall back high
// [RULE9] Both invalid enters invalid-memory flow
// [RULE10] Invalid memory routes SWD onto SBU
// [RULE11] Flash accepts 12 MHz serial clock
// [RULE12] Flash holds at least 1 Mbyte
// [RULE13] Mode 0, first bit with select active
// [RULE14] Flash select active low during transfer
// [RULE15] Shift on falling, sample on rising edge
// [RULE16] Serial clock idles low
// [RULE17] Flash erases 4 kB sectors
// [RULE18] Address is 01, strap 2, strap 1, 111
// [RULE19] Dead battery: supply invalid, VBUS valid
// [RULE20] Reads use command, 24-bit address, data
`include "bfl_regs.vh"
module bfl_boot_loader (
  input wire clk_in,
  input wire reset_n_in,
  input wire address_strap_1_in,
  input wire address_strap_2_in,
  input wire system_supply_in,
  input wire vbus_valid_in,
  input wire dead_battery_path_select_in,
  input wire flash_data_in,
  output reg flash_select_n_out,
  output reg flash_clk_out,
  output reg flash_data_out,
  output reg [6:0] target_address_out,
  output reg host_if_enable_out,
  output reg dead_battery_out,
  output reg bus_power_path_out,
  output reg cfg_valid_out,
  output reg [7:0] cfg_data_out,
  output reg [23:0] firmware_start_out,
  output reg boot_done_out,
  output reg high_region_used_out,
  output reg swd_on_sbu_out
);
  localparam [10:0] S_STRAP = 11'h001;
  localparam [10:0] S_SUPPLY = 11'h002;
  localparam [10:0] S_DEADBAT = 11'h004;
  localparam [10:0] S_HDR_CMD = 11'h008;
  localparam [10:0] S_HDR_DATA = 11'h010;
  localparam [10:0] S_HDR_CHECK = 11'h020;
  localparam [10:0] S_IMG_CMD = 11'h040;
  localparam [10:0] S_IMG_DATA = 11'h080;
  localparam [10:0] S_GAP = 11'h100;
  localparam [10:0] S_DONE = 11'h200;
  localparam [10:0] S_INVALID = 11'h400;

  // Two-flop synchronisers for all pins
  reg [4:0] sync1;
  reg [4:0] sync2;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {flash_data_in, dead_battery_path_select_in, vbus_valid_in,
                system_supply_in, address_strap_2_in};
      sync2 <= sync1;
    end
  end
  reg strap1_s1;
  reg strap1_s2;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap1_s1 <= 1'b0;
      strap1_s2 <= 1'b0;
    end else begin
      strap1_s1 <= address_strap_1_in;
      strap1_s2 <= strap1_s1;
    end
  end
  wire strap2_s = sync2[0];
  wire supply_s = sync2[1];
  wire vbus_s = sync2[2];
  wire path_s = sync2[3];
  wire miso_s = sync2[4];

  reg [10:0] state;
  reg [1:0] settle;
  reg hi;
  reg [2:0] idx;
  reg [7:0] tx;
  reg start;
  reg pending;
  reg [23:0] region_pointer;
  reg [23:0] code_offset_in_region;
  reg [31:0] check;
  reg [7:0] cfg_cnt;
  wire done;
  wire [7:0] rx;
  wire sck;
  wire mosi;
  wire [23:0] hdr_addr = hi ? `BFL_HIGH_HEADER_ADDR : `BFL_LOW_HEADER_ADDR;
  wire [23:0] cmd_addr = (state == S_HDR_CMD) ? hdr_addr : firmware_start_out;

  bfl_spi_shift i_bfl_spi_shift (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(start),
    .tx_byte_in(tx),
    .miso_in(miso_s),
    .done_out(done),
    .rx_byte_out(rx),
    .sck_out(sck),
    .mosi_out(mosi)
  );

  always @* begin
    case (idx)
      3'h0: tx = `BFL_READ_CMD; // [RULE20]
      3'h1: tx = cmd_addr[23:16];
      3'h2: tx = cmd_addr[15:8];
      3'h3: tx = cmd_addr[7:0];
      default: tx = 8'h00;
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_clk_out <= 1'b0;
      flash_data_out <= 1'b0;
    end else begin
      flash_clk_out <= sck; // [RULE16]
      flash_data_out <= mosi; // [RULE13]
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= S_STRAP;
      settle <= 2'h0;
      hi <= 1'b0;
      idx <= 3'h0;
      start <= 1'b0;
      pending <= 1'b0;
      region_pointer <= 24'h000000;
      code_offset_in_region <= 24'h000000;
      check <= 32'h00000000;
      cfg_cnt <= 8'h00;
      flash_select_n_out <= 1'b1;
      target_address_out <= 7'h00;
      host_if_enable_out <= 1'b0;
      dead_battery_out <= 1'b0;
      bus_power_path_out <= 1'b0;
      cfg_valid_out <= 1'b0;
      cfg_data_out <= 8'h00;
      firmware_start_out <= 24'h000000;
      boot_done_out <= 1'b0;
      high_region_used_out <= 1'b0;
      swd_on_sbu_out <= 1'b0;
    end else begin
      start <= 1'b0;
      cfg_valid_out <= 1'b0;
      case (state)
        S_STRAP: begin
          // Wait for synchronisers to fill before trusting straps
          settle <= settle + 2'h1;
          if (settle == 2'h3) begin
            target_address_out <= {`BFL_ADDR_UPPER, strap2_s, strap1_s2,
                                   `BFL_ADDR_LOWER}; // [RULE18] [RULE1]
            host_if_enable_out <= 1'b1; // [RULE1]
            state <= S_SUPPLY;
          end
        end
        S_SUPPLY: begin
          if (!supply_s && vbus_s) begin // [RULE19] [RULE2]
            dead_battery_out <= 1'b1;
            state <= S_DEADBAT;
          end else begin
            state <= S_HDR_CMD;
          end
        end
        S_DEADBAT: begin
          bus_power_path_out <= path_s; // [RULE3]
          state <= S_HDR_CMD;
        end
        S_HDR_CMD, S_IMG_CMD: begin
          flash_select_n_out <= 1'b0; // [RULE14]
          if (!pending) begin
            start <= 1'b1; // [RULE13]
            pending <= 1'b1;
          end else if (done) begin
            pending <= 1'b0;
            if (idx == 3'h3) begin
              idx <= 3'h0;
              state <= (state == S_HDR_CMD) ? S_HDR_DATA : S_IMG_DATA;
            end else begin
              idx <= idx + 3'h1;
            end
          end
        end
        S_HDR_DATA: begin
          // Header: region pointer then offset, 3 bytes each, MSB first
          if (!pending) begin
            start <= 1'b1;
            pending <= 1'b1;
          end else if (done) begin
            pending <= 1'b0;
            if (idx < 3'h3)
              region_pointer <= {region_pointer[15:0], rx};
            else
              code_offset_in_region <= {code_offset_in_region[15:0], rx};
            if (idx == 3'h5) begin
              idx <= 3'h0;
              flash_select_n_out <= 1'b1;
              state <= S_HDR_CHECK;
            end else begin
              idx <= idx + 3'h1;
            end
          end
        end
        S_HDR_CHECK: begin
          firmware_start_out <= region_pointer + code_offset_in_region; // [RULE6]
          // Erased or header-overlapping pointers are invalid
          if ((region_pointer == 24'hffffff) || (code_offset_in_region == 24'hffffff) ||
              (region_pointer < `BFL_HEADER_BYTES + `BFL_HEADER_BYTES)) begin // [RULE5]
            state <= S_GAP;
          end else begin
            state <= S_IMG_CMD;
          end
        end
        S_IMG_DATA: begin
          if (!pending) begin
            start <= 1'b1;
            pending <= 1'b1;
          end else if (done) begin
            pending <= 1'b0;
            cfg_valid_out <= 1'b1; // [RULE7]
            cfg_data_out <= rx;
            check <= {check[23:0], rx};
            cfg_cnt <= cfg_cnt + 8'h01;
            if (cfg_cnt == `BFL_CFG_BYTES - 8'h01) begin
              flash_select_n_out <= 1'b1;
              cfg_cnt <= 8'h00;
              if ({check[23:0], rx} == `BFL_ERASED_WORD)
                state <= S_GAP; // [RULE8]
              else
                state <= S_DONE;
            end
          end
        end
        S_GAP: begin
          // Failed region: fall back once, then give up
          flash_select_n_out <= 1'b1;
          if (!hi) begin
            hi <= 1'b1; // [RULE8] [RULE4]
            state <= S_HDR_CMD;
          end else begin
            state <= S_INVALID; // [RULE9]
          end
        end
        S_DONE: begin
          boot_done_out <= 1'b1;
          high_region_used_out <= hi;
        end
        S_INVALID: begin
          swd_on_sbu_out <= 1'b1; // [RULE10]
        end
        default: state <= S_STRAP;
      endcase
    end
  end
endmodule

// ---- bfl_boot_loader_monitor.sv ----
module bfl_boot_loader_monitor (
  input wire clk_in,
  input wire reset_n_in,
  input wire system_supply_in,
  input wire vbus_valid_in,
  input wire dead_battery_path_select_in,
  input wire flash_select_n_out,
  input wire flash_clk_out,
  input wire flash_data_out,
  input wire [6:0] target_address_out,
  input wire host_if_enable_out,
  input wire dead_battery_out,
  input wire bus_power_path_out,
  input wire cfg_valid_out,
  input wire boot_done_out,
  input wire swd_on_sbu_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_addr_format: assert property (
    host_if_enable_out |-> target_address_out[6:5] == 2'h1 &&
    target_address_out[2:0] == 3'h7) else $error("address format");
  a_addr_held: assert property (
    host_if_enable_out |=> $stable(target_address_out))
    else $error("address moved");
  a_flash_after: assert property (
    !host_if_enable_out |-> flash_select_n_out)
    else $error("flash used before host enable");
  a_sck_idle: assert property (
    flash_select_n_out |-> !flash_clk_out) else $error("clock not idle");
  a_mosi_low: assert property (
    $changed(flash_data_out) |-> !flash_clk_out)
    else $error("data moved while clock high");
  a_sck_high: assert property (
    $rose(flash_clk_out) |-> flash_clk_out[*8] ##1 !flash_select_n_out)
    else $error("short clock high phase");
  // Select rises on the very edge that ends the last bit
  a_sel_frame: assert property (
    $rose(flash_select_n_out) |-> $fell(flash_clk_out))
    else $error("select released mid bit");
  a_dead_cause: assert property (
    dead_battery_out |-> !system_supply_in && vbus_valid_in)
    else $error("dead battery without cause");
  // Path is taken one cycle after the flag is raised
  a_path_copy: assert property (
    dead_battery_out |=> bus_power_path_out == dead_battery_path_select_in)
    else $error("power path wrong");
  a_cfg_gap: assert property (
    cfg_valid_out |=> !cfg_valid_out[*8]) else $error("config too close");
  a_swd_excl: assert property (
    swd_on_sbu_out |-> !boot_done_out) else $error("swd with code");
endmodule

// ---- bfl_boot_loader_tb.sv ----
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module bfl_boot_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_n_in, st1, st2, sup, vb, ps, miso, sel_n, sck, mosi;
  logic hie, dead, path, cv, done, high, swd;
  logic [6:0] ta;
  logic [7:0] cd;
  logic [23:0] fs;
  logic [7:0] q [$];
  int n_errors = 0;
  int checked = 0;
  bfl_boot_loader i_bfl_boot_loader (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .address_strap_1_in(st1),
    .address_strap_2_in(st2), .system_supply_in(sup), .vbus_valid_in(vb),
    .dead_battery_path_select_in(ps), .flash_data_in(miso),
    .flash_select_n_out(sel_n), .flash_clk_out(sck), .flash_data_out(mosi),
    .target_address_out(ta), .host_if_enable_out(hie),
    .dead_battery_out(dead), .bus_power_path_out(path), .cfg_valid_out(cv),
    .cfg_data_out(cd), .firmware_start_out(fs), .boot_done_out(done),
    .high_region_used_out(high), .swd_on_sbu_out(swd));
  bfl_flash_model i_flash (.flash_select_n_in(sel_n), .flash_clk_in(sck),
    .flash_data_in(mosi), .flash_data_out(miso));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Mid-cycle sampling keeps clear of the launching edge
  always @(negedge clk_in) if (cv === 1'b1) q.push_back(cd);
  task automatic hdr(int a, logic [23:0] p, logic [23:0] o, logic [7:0] s);
    for (int i = 0; i < 3; i++) begin
      i_flash.mem[a + i] = p[23 - 8 * i -: 8];
      i_flash.mem[a + 3 + i] = o[23 - 8 * i -: 8];
    end
    for (int i = 0; i < 16; i++) i_flash.mem[p + o + i] = s + i[7:0];
  endtask
  task automatic boot(logic [4:0] v, logic [23:0] f, logic h, logic [7:0] s);
    @(negedge clk_in);
    {st1, st2, sup, vb, ps} = v;
    reset_n_in = 1'b0;
    q.delete();
    repeat (12) @(negedge clk_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 20000 && done !== 1'b1 && swd !== 1'b1; i++)
      @(negedge clk_in);
    repeat (4) @(negedge clk_in);
    `CHK(ta, {2'h1, st2, st1, 3'h7})
    `CHK(hie, 1'b1)
    `CHK(dead, !sup && vb)
    if (dead === 1'b1) `CHK(path, ps)
    `CHK(swd, s == 8'h00)
    `CHK(done, s != 8'h00)
    if (s != 8'h00) begin
      `CHK(fs, f)
      `CHK(high, h)
      `CHK(q.size() >= 16, 1'b1)
      for (int i = 0; i < 16; i++)
        `CHK(q[q.size() - 16 + i], s + i[7:0])
    end
  endtask
  task automatic t_low_ok;
    i_flash.mem.delete();
    hdr(0, 24'h002000, 24'h000010, 8'h10);
    hdr(4096, 24'h004000, 24'h000020, 8'h80);
    boot(5'h0b, 24'h002010, 1'b0, 8'h10);
  endtask
  task automatic t_low_ptr_bad;
    i_flash.mem.delete();
    hdr(0, 24'h001ff0, 24'h000100, 8'h20);
    hdr(4096, 24'h004000, 24'h000020, 8'h80);
    boot(5'h13, 24'h004020, 1'b1, 8'h80);
  endtask
  task automatic t_low_img_bad;
    t_low_ok();
    for (int i = 12; i < 16; i++) i_flash.mem[24'h002010 + i] = 8'hff;
    boot(5'h1a, 24'h004020, 1'b1, 8'h80);
  endtask
  task automatic t_both_bad;
    i_flash.mem.delete();
    // Supply valid: no dead-battery detour; empty flash fails both regions, SWD expected
    boot(5'h16, 24'h0, 1'b0, 8'h00);
  endtask
  task automatic results;
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {reset_n_in, st1, st2, sup, vb, ps} = 6'h00;
    t_low_ok();
    t_low_ptr_bad();
    t_low_img_bad();
    t_both_bad();
    results();
  end
  initial begin
    #360000;
    n_errors++;
    results();
  end
endmodule
bind bfl_boot_loader bfl_boot_loader_monitor i_mon (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .system_supply_in(system_supply_in),
  .vbus_valid_in(vbus_valid_in), .flash_data_out(flash_data_out),
  .dead_battery_path_select_in(dead_battery_path_select_in),
  .flash_select_n_out(flash_select_n_out), .flash_clk_out(flash_clk_out),
  .target_address_out(target_address_out), .cfg_valid_out(cfg_valid_out),
  .host_if_enable_out(host_if_enable_out), .boot_done_out(boot_done_out),
  .dead_battery_out(dead_battery_out), .swd_on_sbu_out(swd_on_sbu_out),
  .bus_power_path_out(bus_power_path_out));

// ---- bfl_flash_model.sv ----
module bfl_flash_model (
  input wire flash_select_n_in,
  input wire flash_clk_in,
  input wire flash_data_in,
  output logic flash_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [31:0] sh;
  logic [7:0] b;
  int n = 0;
  initial flash_data_out = 1'b0;
  always @(posedge flash_select_n_in) begin
    n = 0;
    flash_data_out = ~flash_data_out; // Released line keeps no stale bit
  end
  // Any clock rate is accepted, 12 MHz included
  always @(posedge flash_clk_in) if (!flash_select_n_in) begin
    if (n < 32) sh = {sh[30:0], flash_data_in};
    n++;
  end
  always @(negedge flash_clk_in) if (!flash_select_n_in) begin
    if (n >= 32 && sh[31:24] == 8'h03) begin
      b = mem.exists(sh[23:0] + (n - 32) / 8) ?
        mem[sh[23:0] + (n - 32) / 8] : 8'hff;
      flash_data_out = b[7 - (n - 32) % 8];
    end else flash_data_out = ~flash_data_out;
  end
endmodule

// ---- bfl_regs.vh ----
`ifndef BFL_REGS_VH
`define BFL_REGS_VH
`define BFL_LOW_HEADER_ADDR 24'h000000
`define BFL_HIGH_HEADER_ADDR 24'h001000
`define BFL_HEADER_BYTES 24'h001000
`define BFL_READ_CMD 8'h03
`define BFL_ADDR_UPPER 2'h1
`define BFL_ADDR_LOWER 3'h7
`define BFL_CLK_MHZ 250
`define BFL_SCK_MHZ 12
`define BFL_SCK_HALF_CYCLES (((`BFL_CLK_MHZ) + 2 * (`BFL_SCK_MHZ) - 1) / (2 * (`BFL_SCK_MHZ)))
`define BFL_CFG_BYTES 8'h10
`define BFL_ERASED_WORD 32'hffffffff
`endif

// ---- bfl_spi_shift.v ----
`include "bfl_regs.vh"
module bfl_spi_shift (
  input wire clk_in,
  input wire reset_n_in,
  input wire start_in,
  input wire [7:0] tx_byte_in,
  input wire miso_in,
  output reg done_out,
  output reg [7:0] rx_byte_out,
  output reg sck_out,
  output reg mosi_out
);
  // Rounded up so the link never runs faster than the flash allows
  localparam integer HALF_INT = `BFL_SCK_HALF_CYCLES;
  localparam [4:0] HALF = HALF_INT[4:0];
  reg [4:0] div;
  reg [3:0] bits;
  reg busy;
  reg [7:0] sh;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div <= 5'h00;
      bits <= 4'h0;
      busy <= 1'b0;
      sh <= 8'h00;
      done_out <= 1'b0;
      rx_byte_out <= 8'h00;
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy) begin
        busy <= 1'b1;
        bits <= 4'h0;
        div <= 5'h00;
        mosi_out <= tx_byte_in[7];
        sh <= {tx_byte_in[6:0], 1'b0};
      end else if (busy) begin
        if (div == HALF - 5'h01) begin
          div <= 5'h00;
          if (!sck_out) begin
            sck_out <= 1'b1;
            rx_byte_out <= {rx_byte_out[6:0], miso_in}; // [RULE15]
          end else begin
            sck_out <= 1'b0;
            if (bits == 4'h7) begin
              busy <= 1'b0;
              done_out <= 1'b1;
            end else begin
              mosi_out <= sh[7]; // [RULE15]
              sh <= {sh[6:0], 1'b0};
            end
            bits <= bits + 4'h1;
          end
        end else begin
          div <= div + 5'h01;
        end
      end
    end
  end
endmodule
